//--- hw/aux_cfg_pkg.sv
`default_nettype none
package aux_cfg_pkg;
   // register byte offsets inside the upstream port configuration space
   localparam logic [7:0]  DEBUG_READOUT_OFS   = 8'hac;
   localparam logic [7:0]  CAP_HEADER_OFS      = 8'hb0;
   localparam logic [7:0]  SUBSYS_IDENT_OFS    = 8'hb4;
   localparam logic [7:0]  PIN_CONTROL_OFS     = 8'hb8;
   // debug readout
   localparam logic [4:0]  DEBUG_MODE_LINK     = 5'h0c;
   localparam int          LINK_STATE_W        = 11;
   localparam int          LINK_GAP_BIT        = 7;
   localparam logic [31:0] WORD_ZERO           = 32'h0000_0000;
   // subsystem identification capability header
   localparam logic [7:0]  SUBSYS_CAP_ID       = 8'h0d;
   localparam logic [7:0]  SUBSYS_NEXT_PTR     = 8'hc0;
   // neutral power-up identifiers, values are arbitrary
   localparam logic [15:0] VENDOR_CODE_DEFAULT = 16'h5a5a;
   localparam logic [15:0] DEVICE_CODE_DEFAULT = 16'ha5a5;
   // general pin control layout, one 4-bit group per pin
   localparam int          PIN_COUNT           = 8;
   localparam int          PM_PIN_COUNT        = 5;
   localparam int          PIN_GROUP_W         = 4;
   localparam int          PIN_IN_BIT          = 0;
   localparam int          PIN_DIR_BIT         = 1;
   localparam int          PIN_OUT_BIT         = 2;
   localparam logic        PIN_IN_RESET        = 1'b1;
   localparam logic        PIN_DIR_RESET       = 1'b0;
   localparam logic        PIN_OUT_RESET       = 1'b0;
endpackage : aux_cfg_pkg
`default_nettype wire

//--- hw/general_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
module general_pin_cell (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic pin_in,
   input  wire logic wr_en,
   input  wire logic wr_dir,
   input  wire logic wr_out,
   input  wire logic pm_en,
   input  wire logic pm_value,
   output logic      in_level,
   output logic      dir,
   output logic      out_value,
   output logic      pin_out,
   output logic      pin_oe
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic dir;
      logic outv;
      logic pin_out;
      logic pin_oe;
   } cell_state_t;

   cell_state_t s_q;
   cell_state_t s_d;

   // next state: two-flop synchroniser, control bits, pin drive
   always_comb begin
      s_d       = s_q;
      s_d.sync1 = pin_in;
      s_d.sync2 = s_q.sync1;
      if (wr_en) begin
         s_d.dir  = wr_dir;
         s_d.outv = wr_out;
      end
      // power control takes the pin over, register value is then ignored
      if (pm_en) begin
         s_d.pin_out = pm_value;
         s_d.pin_oe  = 1'b1;
      end else begin
         s_d.pin_out = s_q.outv;
         s_d.pin_oe  = s_q.dir;
      end
   end

   // sync reset, pin level reads high until the pin is sampled
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q <= '{sync1: aux_cfg_pkg::PIN_IN_RESET, sync2: aux_cfg_pkg::PIN_IN_RESET,
                  dir: aux_cfg_pkg::PIN_DIR_RESET, outv: aux_cfg_pkg::PIN_OUT_RESET,
                  pin_out: aux_cfg_pkg::PIN_OUT_RESET, pin_oe: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign in_level  = s_q.sync2;
   assign dir       = s_q.dir;
   assign out_value = s_q.outv;
   assign pin_out   = s_q.pin_out;
   assign pin_oe    = s_q.pin_oe;

   property p_reg_drive;
      @(posedge mclk) disable iff (reset)
      !pm_en |=> (pin_out == $past(s_q.outv)) && (pin_oe == $past(s_q.dir));
   endproperty
   a_reg_drive: assert property (p_reg_drive) else $error("pin not driven from register");

   property p_pm_drive;
      @(posedge mclk) disable iff (reset)
      pm_en |=> pin_oe && (pin_out == $past(pm_value));
   endproperty
   a_pm_drive: assert property (p_pm_drive) else $error("power control not on pin");

   property p_in_sync;
      @(posedge mclk) disable iff (reset)
      !$past(reset) && !$past(reset, 2) |-> in_level == $past(pin_in, 2);
   endproperty
   a_in_sync: assert property (p_in_sync) else $error("pin level not two cycles late");
endmodule : general_pin_cell
`default_nettype wire

//--- hw/switch_aux_config_registers.sv
`timescale 1ns/100ps
`default_nettype none
module switch_aux_config_registers #(
   parameter int        PINS       = aux_cfg_pkg::PIN_COUNT,
   parameter int        PM_PINS    = aux_cfg_pkg::PM_PIN_COUNT,
   parameter logic [15:0] VENDOR_DEFAULT = aux_cfg_pkg::VENDOR_CODE_DEFAULT,
   parameter logic [15:0] DEVICE_DEFAULT = aux_cfg_pkg::DEVICE_CODE_DEFAULT
) (
   input  wire logic                                  mclk,
   input  wire logic                                  reset,
   // configuration access
   input  wire logic                                  cfg_rd,
   input  wire logic                                  cfg_wr,
   input  wire logic [7:0]                            cfg_addr,
   input  wire logic [3:0]                            cfg_be,
   input  wire logic [31:0]                           cfg_wdata,
   output logic      [31:0]                           cfg_rdata,
   output logic                                       cfg_rack,
   // debug selection held by the neighbouring control register
   input  wire logic [4:0]                            debug_mode_sel,
   input  wire logic [aux_cfg_pkg::LINK_STATE_W-1:0]  link_state,
   // identifier loader (serial management or autoload)
   input  wire logic                                  id_load,
   input  wire logic [15:0]                           id_load_vendor,
   input  wire logic [15:0]                           id_load_device,
   // downstream power management controls
   input  wire logic [PM_PINS-1:0]                    pm_cap_en,
   input  wire logic [PM_PINS-1:0]                    port_power,
   // board pins
   input  wire logic [PINS-1:0]                       pin_in,
   output logic      [PINS-1:0]                       pin_out,
   output logic      [PINS-1:0]                       pin_oe
);
   typedef struct packed {
      logic [31:0] debug;
      logic [15:0] vendor;
      logic [15:0] device;
      logic [31:0] rdata;
      logic        rack;
   } regs_state_t;

   regs_state_t s_q;
   regs_state_t s_d;

   logic [PINS-1:0] in_level;
   logic [PINS-1:0] dir;
   logic [PINS-1:0] out_value;
   logic [PINS-1:0] pin_wr;
   logic [31:0]     pin_word;
   logic [31:0]     link_word;
   logic            pin_wr_hit;

   assign pin_wr_hit = cfg_wr && (cfg_addr == aux_cfg_pkg::PIN_CONTROL_OFS);

   // one cell per pin, only the lower pins see power control
   for (genvar n = 0; n < PINS; n++) begin : g_pin
      logic pm_en_n;
      logic pm_val_n;
      if (n < PM_PINS) begin : g_pm
         assign pm_en_n  = pm_cap_en[n];
         assign pm_val_n = port_power[n];
      end else begin : g_nopm
         assign pm_en_n  = 1'b0;
         assign pm_val_n = 1'b0;
      end
      // two groups share a byte lane
      assign pin_wr[n] = pin_wr_hit && cfg_be[n/2];
      general_pin_cell u_cell (
         .mclk      (mclk),
         .reset     (reset),
         .pin_in    (pin_in[n]),
         .wr_en     (pin_wr[n]),
         .wr_dir    (cfg_wdata[n*aux_cfg_pkg::PIN_GROUP_W + aux_cfg_pkg::PIN_DIR_BIT]),
         .wr_out    (cfg_wdata[n*aux_cfg_pkg::PIN_GROUP_W + aux_cfg_pkg::PIN_OUT_BIT]),
         .pm_en     (pm_en_n),
         .pm_value  (pm_val_n),
         .in_level  (in_level[n]),
         .dir       (dir[n]),
         .out_value (out_value[n]),
         .pin_out   (pin_out[n]),
         .pin_oe    (pin_oe[n])
      );
   end

   // pin control word, spare bit of each group stays zero
   always_comb begin
      pin_word = aux_cfg_pkg::WORD_ZERO;
      for (int n = 0; n < PINS; n++) begin
         pin_word[n*aux_cfg_pkg::PIN_GROUP_W + aux_cfg_pkg::PIN_IN_BIT]  = in_level[n];
         pin_word[n*aux_cfg_pkg::PIN_GROUP_W + aux_cfg_pkg::PIN_DIR_BIT] = dir[n];
         pin_word[n*aux_cfg_pkg::PIN_GROUP_W + aux_cfg_pkg::PIN_OUT_BIT] = out_value[n];
      end
   end

   // training state as one-hot word, the unused position is masked off
   always_comb begin
      link_word = aux_cfg_pkg::WORD_ZERO;
      link_word[aux_cfg_pkg::LINK_STATE_W-1:0] = link_state;
      link_word[aux_cfg_pkg::LINK_GAP_BIT]     = 1'b0;
   end

   // next state: debug capture, identifier load, read answer
   always_comb begin
      s_d      = s_q;
      s_d.rack = cfg_rd;
      // other modes are outside this block and read as zero
      if (debug_mode_sel == aux_cfg_pkg::DEBUG_MODE_LINK) begin
         s_d.debug = link_word;
      end else begin
         s_d.debug = aux_cfg_pkg::WORD_ZERO;
      end
      // configuration writes never reach the identifiers
      if (id_load) begin
         s_d.vendor = id_load_vendor;
         s_d.device = id_load_device;
      end
      if (cfg_rd) begin
         unique case (cfg_addr)
            aux_cfg_pkg::DEBUG_READOUT_OFS: s_d.rdata = s_q.debug;
            aux_cfg_pkg::CAP_HEADER_OFS:
               s_d.rdata = {16'h0000, aux_cfg_pkg::SUBSYS_NEXT_PTR,
                            aux_cfg_pkg::SUBSYS_CAP_ID};
            aux_cfg_pkg::SUBSYS_IDENT_OFS:  s_d.rdata = {s_q.device, s_q.vendor};
            aux_cfg_pkg::PIN_CONTROL_OFS:   s_d.rdata = pin_word;
            default:                        s_d.rdata = aux_cfg_pkg::WORD_ZERO;
         endcase
      end
   end

   // sync reset, readout word clears to zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q <= '{debug: aux_cfg_pkg::WORD_ZERO, vendor: VENDOR_DEFAULT,
                  device: DEVICE_DEFAULT, rdata: aux_cfg_pkg::WORD_ZERO, rack: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign cfg_rdata = s_q.rdata;
   assign cfg_rack  = s_q.rack;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_read(logic [7:0] ofs);
      cfg_rd && (cfg_addr == ofs);
   endsequence

   sequence s_answer;
      cfg_rack;
   endsequence

   property p_debug_link;
      debug_mode_sel == aux_cfg_pkg::DEBUG_MODE_LINK
         |=> s_q.debug == {21'h0, $past(link_state) & 11'h77f};
   endproperty
   a_debug_link: assert property (p_debug_link) else $error("link state not shown");

   property p_debug_gap;
      1'b1 |=> (s_q.debug[aux_cfg_pkg::LINK_GAP_BIT] == 1'b0) && (s_q.debug[31:11] == 21'h0);
   endproperty
   a_debug_gap: assert property (p_debug_gap) else $error("debug spare bits set");

   property p_debug_other;
      debug_mode_sel != aux_cfg_pkg::DEBUG_MODE_LINK |=> s_q.debug == aux_cfg_pkg::WORD_ZERO;
   endproperty
   a_debug_other: assert property (p_debug_other) else $error("debug word not clear");

   property p_cap_read;
      s_read(aux_cfg_pkg::CAP_HEADER_OFS) |=> s_answer ##0 cfg_rdata == 32'h0000_c00d;
   endproperty
   a_cap_read: assert property (p_cap_read) else $error("capability header wrong");

   property p_ident_ro;
      cfg_wr && !id_load |=> $stable(s_q.vendor) && $stable(s_q.device);
   endproperty
   a_ident_ro: assert property (p_ident_ro) else $error("identifier changed by write");

   property p_ident_load;
      id_load ##1 (cfg_rd && (cfg_addr == aux_cfg_pkg::SUBSYS_IDENT_OFS) && !id_load)
         |=> cfg_rdata == {$past(id_load_device, 2), $past(id_load_vendor, 2)};
   endproperty
   a_ident_load: assert property (p_ident_load) else $error("loaded identifier lost");

   property p_pin_spare;
      s_read(aux_cfg_pkg::PIN_CONTROL_OFS)
         |=> s_answer ##0 (cfg_rdata & 32'h8888_8888) == aux_cfg_pkg::WORD_ZERO;
   endproperty
   a_pin_spare: assert property (p_pin_spare) else $error("spare pin bits set");

   property p_pin_write;
      pin_wr_hit && (cfg_be == 4'hf) |=> dir == {$past(cfg_wdata[29]), $past(cfg_wdata[25]),
         $past(cfg_wdata[21]), $past(cfg_wdata[17]), $past(cfg_wdata[13]),
         $past(cfg_wdata[9]), $past(cfg_wdata[5]), $past(cfg_wdata[1])};
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("direction bits not written");

   property p_unmapped;
      cfg_rd && (cfg_addr[7:4] != 4'ha) && (cfg_addr[7:4] != 4'hb)
         |=> s_answer ##0 cfg_rdata == aux_cfg_pkg::WORD_ZERO;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : switch_aux_config_registers
`default_nettype wire

//--- testbench/gpio_board_model.sv
`timescale 1ns/100ps
`default_nettype none
// board side of the eight pins; a pin the device drives reads back its own drive
module gpio_board_model (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] board_drv,
   output logic      [7:0] pin_in
);
   // board level only shows where the device has let go, so no stale value leaks
   always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & board_drv);
endmodule : gpio_board_model
`default_nettype wire

//--- testbench/tb_switch_aux_config_registers.sv
`timescale 1ns/100ps
`default_nettype none
module tb_switch_aux_config_registers;
   logic        mclk, reset, cfg_rd, cfg_wr, id_load;
   logic [7:0]  cfg_addr, pin_in, pin_out, pin_oe, board_drv;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata;
   logic        cfg_rack;
   logic [4:0]  debug_mode_sel, pm_cap_en, port_power;
   logic [10:0] link_state;
   logic [15:0] id_load_vendor, id_load_device;
   int          fail_count = 0;
   int          tests_run = 0;

   switch_aux_config_registers DUT (
      .mclk(mclk), .reset(reset), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rack(cfg_rack),
      .debug_mode_sel(debug_mode_sel), .link_state(link_state), .id_load(id_load),
      .id_load_vendor(id_load_vendor), .id_load_device(id_load_device),
      .pm_cap_en(pm_cap_en), .port_power(port_power), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe)
   );
   gpio_board_model board (
      .pin_out(pin_out), .pin_oe(pin_oe), .board_drv(board_drv), .pin_in(pin_in)
   );

   // 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic final_report;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // one-cycle write pulse, then an idle cycle so a following call never re-raises it at once
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge mclk);
      cfg_wr = 1'b0;
      @(negedge mclk);
   endtask : cfg_write

   // read pulse, then a bounded wait for the answer strobe
   task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
      int n;
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge mclk);
      cfg_rd = 1'b0;
      n = 0;
      while (cfg_rack !== 1'b1 && n < 3) begin
         @(negedge mclk);
         n++;
      end
      check({31'h0, cfg_rack}, 32'h0000_0001);
      check(cfg_rdata, exp);
      // idle cycle keeps back-to-back reads from reassigning the strobe in one step
      @(negedge mclk);
   endtask : cfg_read

   // pins settle through the two-flop sampler before they are compared
   task automatic pins(input logic [7:0] oe, input logic [7:0] out, input logic [31:0] word);
      repeat (4) @(negedge mclk);
      check({16'h0, pin_oe, pin_out}, {16'h0, oe, out});
      cfg_read(aux_cfg_pkg::PIN_CONTROL_OFS, word);
   endtask : pins

   initial begin
      reset = 1'b1;
      {cfg_rd, cfg_wr, id_load} = 3'h0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
      debug_mode_sel = 5'h00;
      link_state = 11'h000;
      id_load_vendor = 16'h0000;
      id_load_device = 16'h0000;
      {pm_cap_en, port_power} = 10'h000;
      board_drv = 8'hff;
      repeat (6) @(negedge mclk);
      reset = 1'b0;
      // reset state, then read-only words shrug off writes
      pins(8'h00, 8'h00, 32'h1111_1111);
      cfg_read(aux_cfg_pkg::DEBUG_READOUT_OFS, 32'h0000_0000);
      cfg_read(aux_cfg_pkg::CAP_HEADER_OFS, 32'h0000_c00d);
      cfg_read(8'hbc, 32'h0000_0000);
      cfg_read(8'h40, 32'h0000_0000);
      cfg_write(aux_cfg_pkg::DEBUG_READOUT_OFS, 4'hf, 32'hffff_ffff);
      cfg_write(aux_cfg_pkg::CAP_HEADER_OFS, 4'hf, 32'hffff_ffff);
      cfg_write(aux_cfg_pkg::SUBSYS_IDENT_OFS, 4'hf, 32'hffff_ffff);
      cfg_read(aux_cfg_pkg::DEBUG_READOUT_OFS, 32'h0000_0000);
      cfg_read(aux_cfg_pkg::CAP_HEADER_OFS, 32'h0000_c00d);
      cfg_read(aux_cfg_pkg::SUBSYS_IDENT_OFS, 32'ha5a5_5a5a);
      // loader replaces both identifiers
      id_load_vendor = 16'h1234;
      id_load_device = 16'habcd;
      id_load = 1'b1;
      @(negedge mclk);
      id_load = 1'b0;
      cfg_read(aux_cfg_pkg::SUBSYS_IDENT_OFS, 32'habcd_1234);
      // every training state, bit 7 is not a state
      debug_mode_sel = 5'h0c;
      for (int b = 0; b < 11; b++) begin
         link_state = 11'h001 << b;
         repeat (3) @(negedge mclk);
         cfg_read(8'hac, (b == 7) ? 32'h0000_0000 : (32'h0000_0001 << b));
      end
      debug_mode_sel = 5'h0b;
      repeat (3) @(negedge mclk);
      cfg_read(8'hac, 32'h0000_0000);
      // input levels follow the board
      board_drv = 8'h5a;
      pins(8'h00, 8'h00, 32'h0101_1010);
      board_drv = 8'h00;
      cfg_write(8'hb8, 4'hf, 32'hffff_ffff);
      pins(8'hff, 8'hff, 32'h7777_7777);
      cfg_write(8'hb8, 4'h1, 32'h0000_0022);
      pins(8'hff, 8'hfc, 32'h7777_7722);
      cfg_write(8'hb8, 4'h2, 32'h0000_0000);
      pins(8'hf3, 8'hf0, 32'h7777_0022);
      // power control takes pins 0..4 regardless of the register bits
      pm_cap_en = 5'h1f;
      port_power = 5'h05;
      pins(8'hff, 8'he5, 32'h7776_0123);
      pm_cap_en = 5'h00;
      pins(8'hf3, 8'hf0, 32'h7777_0022);
      final_report();
   end

   // whole run is about 140 cycles; this cuts a hang short
   initial begin
      repeat (3000) @(posedge mclk);
      fail_count++;
      final_report();
   end
endmodule : tb_switch_aux_config_registers
`default_nettype wire
